// ### hdl/pldb_fifo.sv
// pldb_fifo: small synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous-release active-low reset.
module pldb_fifo #(
    parameter int W     = 4,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    // fill side
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    // drain side
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic      [W-1:0] o_data
);

    localparam int PW = $clog2(DEPTH);

    // pointer arithmetic wraps, so depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("pldb_fifo: DEPTH must be a power of two of at least 2");
    end

    // ====================================================================
    // state
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [PW:0]   cnt_q, cnt_d;
    logic          push, pop;

    // honest flags straight from the occupancy count
    assign o_ready = (cnt_q != (PW + 1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    // next pointers and count
    always_comb begin
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage, written only on an accepted push
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

endmodule : pldb_fifo

// ### hdl/pldb_pkg.sv
// pldb_pkg: shared constants and types of the print line double buffer.
// assumes every user of it runs on the single block clock.
package pldb_pkg;

    // ====================================================================
    // widths and depths
    localparam int ADDR_W     = 11;   // address counter per bank
    localparam int NIB_W      = 4;    // one y-m-c-k nibble
    localparam int MAP_W      = 8;    // colour map word, two nibbles
    localparam int RGB_W      = 12;   // four bits per colour
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_N     = 3;    // pin synchroniser stages
    localparam int NUM_BANKS  = 2;

    // ====================================================================
    // host byte fields
    localparam int BIT_DATA   = 7;    // high marks a colour data byte
    localparam int BIT_FIRST  = 6;    // high marks first byte of a pixel
    localparam int FLD_RED    = 4;    // two-bit colour fields, low bit
    localparam int FLD_GREEN  = 2;
    localparam int FLD_BLUE   = 0;
    localparam int RGB_RED    = 8;    // low bit of each colour in rgb
    localparam int RGB_GREEN  = 4;
    localparam int RGB_BLUE   = 0;

    // ====================================================================
    // link status codes as {busy, fault_n}
    localparam logic [1:0] LINK_RESEND = 2'h0;
    localparam logic [1:0] LINK_READY  = 2'h1;
    localparam logic [1:0] LINK_ERROR  = 2'h2;
    localparam logic [1:0] LINK_BUSY   = 2'h3;

    // ====================================================================
    // reset values and fixed codes
    localparam logic [ADDR_W-1:0] CNT_RST   = 11'h000;
    localparam logic [ADDR_W-1:0] CNT_MAX   = 11'h7ff;
    localparam logic [NIB_W-1:0]  NIB_BLANK = 4'h0;
    localparam logic [NIB_W-1:0]  NIB_BLACK = 4'h1;
    localparam logic [RGB_W-1:0]  RGB_RST   = 12'h000;
    localparam logic [MAP_W-1:0]  MAP_RST   = 8'h00;
    localparam logic [1:0]        REP_RST   = 2'h0;

    // ====================================================================
    // host byte handler states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MAP,
        ST_PUSH
    } pldb_pix_t;

endpackage : pldb_pkg

// ### hdl/pldb_ram.sv
// pldb_ram: one line buffer bank, a single-port memory with registered read.
// assumes write and read address come from the owner's counter each cycle.
module pldb_ram #(
    parameter int AW = 11,
    parameter int DW = 4
) (
    // clock
    input  wire logic          i_clk,
    // access
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [DW-1:0] i_wdata,
    // read data
    output logic      [DW-1:0] o_rdata
);

    // ====================================================================
    // storage
    logic [DW-1:0] mem [2**AW];

    // no reset on the array: contents are undefined until a line is written
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule : pldb_ram

// ### hdl/pldb_top.sv
// pldb_top: print data path of the host parallel port. host bytes become
// y-m-c-k nibbles through the colour map, pass a fifo and fill one of two
// line banks while the other is read out to the print path.
// assumes control lines come from a local controller on I_MCLK; host
// strobe and dot clock are asynchronous pins.
import pldb_pkg::*;

module pldb_top #(
    parameter int FIFO_D = FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              I_MCLK,
    input  wire logic              I_ARST_N,
    // host port
    input  wire logic [7:0]        I_HOST_DATA,
    input  wire logic              I_HOST_BYTE_STROBE_N,
    output logic                   O_BUSY,
    output logic                   O_FAULT_N,
    output logic                   O_COMMAND_BYTE,
    // controller configuration
    input  wire logic              I_ERROR_COND,
    input  wire logic              I_TWO_BYTE_PIXEL_SEL,
    input  wire logic              I_INVERT_GROUP_SELECT,
    input  wire logic              I_BANK_WRITE_SELECT,
    input  wire logic              I_WRITE_COUNT_CLEAR,
    input  wire logic              I_READ_COUNT_CLEAR,
    input  wire logic              I_TOP_MARGIN_GATE,
    input  wire logic              I_BOTTOM_MARGIN_GATE,
    input  wire logic              I_REP_FACTOR_HI,
    input  wire logic              I_REP_FACTOR_LO,
    // print side
    input  wire logic              I_MERGED_DOT_CLOCK,
    output logic [NIB_W-1:0]       O_PRINT_NIBBLE,
    output logic                   O_STORED_BYTE_STROBE_N,
    output logic                   O_READOUT_ADVANCE_N,
    // controller readback
    output logic [ADDR_W-1:0]      O_WRITE_COUNT,
    output logic [NIB_W-1:0]       O_PRINT_READBACK,
    output logic                   O_WRITE_FULL
);

    if (FIFO_D < 2 || (FIFO_D & (FIFO_D - 1)) != 0) begin : g_bad_fifo
        $error("pldb_top: FIFO_D must be a power of two of at least 2");
    end

    // ====================================================================
    // reset release
    logic [1:0] rst_q;
    logic       rst_n;

    // asynchronous assert, two-flop synchronous release
    always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ====================================================================
    // pin synchronisers: index 0 host strobe (active), 1 dot clock
    logic [1:0] pin_raw;
    logic [1:0] pin_rise;

    assign pin_raw = {I_MERGED_DOT_CLOCK, ~I_HOST_BYTE_STROBE_N};

    for (genvar p = 0; p < 2; p++) begin : g_sync
        logic [SYNC_N-1:0] sh_q, sh_d;
        logic              lvl_q, lvl_d, old_q;

        // a change counts only once stages two and three agree
        always_comb begin
            sh_d  = {sh_q[SYNC_N-2:0], pin_raw[p]};
            lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
        end

        always_ff @(posedge I_MCLK or negedge rst_n) begin
            if (!rst_n) begin
                sh_q  <= '0;
                lvl_q <= 1'b0;
                old_q <= 1'b0;
            end else begin
                sh_q  <= sh_d;
                lvl_q <= lvl_d;
                old_q <= lvl_q;
            end
        end
        assign pin_rise[p] = lvl_q & ~old_q;
    end

    // ====================================================================
    // host byte handler and pixel assembly
    pldb_pix_t        st_q, st_d;
    logic [5:0]       hi_q, hi_d;         // first byte colour bits
    logic             half_q, half_d;     // first byte of pair held
    logic [RGB_W-1:0] rgb_q, rgb_d;
    logic [MAP_W-1:0] map_q, map_d;
    logic             resend_q, resend_d;
    logic             cmd_q, cmd_d;
    logic             strobe, drop;
    logic             fifo_in_rdy;
    logic [NIB_W-1:0] fifo_in;
    logic [5:0]       cur;

    // map: normal group keeps black, invert group swaps black and white
    function automatic logic [MAP_W-1:0] pldb_map(input logic [RGB_W-1:0] rgb);
        logic             c, m, y, blk, wht;
        logic [NIB_W-1:0] g1, g2;
        c   = ~rgb[RGB_RED + 3];
        m   = ~rgb[RGB_GREEN + 3];
        y   = ~rgb[RGB_BLUE + 3];
        blk = c & m & y;
        wht = ~(c | m | y);
        g1  = blk ? NIB_BLACK : {y, m, c, 1'b0};
        g2  = blk ? NIB_BLANK : (wht ? NIB_BLACK : g1);
        return {g1, g2};
    endfunction : pldb_map

    assign strobe  = pin_rise[0];
    assign drop    = strobe & (st_q != ST_IDLE);
    assign cur     = I_HOST_DATA[5:0];
    // data pins are held by the host around its strobe, so the late
    // synchronised edge still samples a settled byte
    assign fifo_in = I_INVERT_GROUP_SELECT ? map_q[NIB_W-1:0]
                                           : map_q[MAP_W-1:NIB_W];

    // next state of the byte handler
    always_comb begin
        st_d     = st_q;
        hi_d     = hi_q;
        half_d   = half_q;
        rgb_d    = rgb_q;
        map_d    = map_q;
        cmd_d    = 1'b0;
        resend_d = resend_q;
        if (strobe) begin
            resend_d = 1'b0;                 // next byte clears the request
        end
        case (st_q)
            ST_IDLE: begin
                if (strobe && !I_HOST_DATA[BIT_DATA]) begin
                    cmd_d = 1'b1;            // command bytes go to the controller
                end else if (strobe && I_TWO_BYTE_PIXEL_SEL && I_HOST_DATA[BIT_FIRST]) begin
                    hi_d   = cur;
                    half_d = 1'b1;
                end else if (strobe && I_TWO_BYTE_PIXEL_SEL) begin
                    half_d = 1'b0;
                    if (half_q) begin
                        rgb_d = {hi_q[FLD_RED +: 2],   cur[FLD_RED +: 2],
                                 hi_q[FLD_GREEN +: 2], cur[FLD_GREEN +: 2],
                                 hi_q[FLD_BLUE +: 2],  cur[FLD_BLUE +: 2]};
                        st_d  = ST_MAP;
                    end else begin
                        resend_d = 1'b1;     // second byte with no first
                    end
                end else if (strobe) begin
                    half_d = 1'b0;
                    rgb_d  = {cur[FLD_RED +: 2], 2'h0, cur[FLD_GREEN +: 2], 2'h0,
                              cur[FLD_BLUE +: 2], 2'h0};
                    st_d   = ST_MAP;
                end
            end
            ST_MAP: begin
                map_d = pldb_map(rgb_q);
                st_d  = ST_PUSH;
            end
            ST_PUSH: begin
                if (fifo_in_rdy) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        // a byte arriving mid-pixel is lost; the set wins over the clear
        if (drop) begin
            resend_d = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            hi_q     <= 6'h00;
            half_q   <= 1'b0;
            rgb_q    <= RGB_RST;
            map_q    <= MAP_RST;
            resend_q <= 1'b0;
            cmd_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            hi_q     <= hi_d;
            half_q   <= half_d;
            rgb_q    <= rgb_d;
            map_q    <= map_d;
            resend_q <= resend_d;
            cmd_q    <= cmd_d;
        end
    end

    // ====================================================================
    // link status lines
    logic [1:0] link_q, link_d;

    // error outranks resend, resend outranks busy
    always_comb begin
        if (I_ERROR_COND) begin
            link_d = LINK_ERROR;
        end else if (resend_q) begin
            link_d = LINK_RESEND;
        end else if (st_q != ST_IDLE || strobe) begin
            link_d = LINK_BUSY;
        end else begin
            link_d = LINK_READY;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            link_q <= LINK_READY;
        end else begin
            link_q <= link_d;
        end
    end
    assign O_BUSY         = link_q[1];
    assign O_FAULT_N      = link_q[0];
    assign O_COMMAND_BYTE = cmd_q;

    // ====================================================================
    // nibble fifo in front of the write bank
    logic             fifo_out_vld;
    logic [NIB_W-1:0] fifo_out;
    logic             wr_full_q, wr_full_d;
    logic             store;

    pldb_fifo #(
        .W     (NIB_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .i_clk   (I_MCLK),
        .i_rst_n (rst_n),
        .i_valid (st_q == ST_PUSH),
        .o_ready (fifo_in_rdy),
        .i_data  (fifo_in),
        .o_valid (fifo_out_vld),
        .i_ready (~wr_full_q),
        .o_data  (fifo_out)
    );

    // a full line stalls the fifo, which in turn holds the host busy
    assign store = fifo_out_vld & ~wr_full_q;

    // ====================================================================
    // replication divider
    logic [1:0] rep_sel;
    logic [1:0] rep_q, rep_d, div_q, div_d;
    logic       adv_q, adv_d;

    assign rep_sel = {I_REP_FACTOR_HI, I_REP_FACTOR_LO};

    // binary select n-1, one advance on every n-th dot edge
    always_comb begin
        rep_d = rep_sel;
        div_d = div_q;
        adv_d = 1'b0;
        if (rep_sel != rep_q) begin
            div_d = 2'h0;
        end else if (pin_rise[1]) begin
            if (div_q == rep_q) begin
                div_d = 2'h0;
                adv_d = 1'b1;
            end else begin
                div_d = div_q + 2'h1;
            end
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rep_q <= REP_RST;
            div_q <= 2'h0;
            adv_q <= 1'b0;
        end else begin
            rep_q <= rep_d;
            div_q <= div_d;
            adv_q <= adv_d;
        end
    end

    // ====================================================================
    // two banks: counter and memory each
    logic [ADDR_W-1:0] cnt_q [NUM_BANKS];
    logic [NIB_W-1:0]  bank_rd [NUM_BANKS];
    logic [1:0]        is_wr;

    // bank 0 is A, written while bank select is high
    assign is_wr = I_BANK_WRITE_SELECT ? 2'b01 : 2'b10;

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic [ADDR_W-1:0] cnt_d;
        logic              inc, clr;

        // write bank counts stores, read bank counts advances
        assign inc = is_wr[b] ? store : adv_q;
        assign clr = is_wr[b] ? I_WRITE_COUNT_CLEAR : I_READ_COUNT_CLEAR;

        always_comb begin
            if (clr) begin
                cnt_d = CNT_RST;
            end else if (inc) begin
                cnt_d = cnt_q[b] + 11'h001;
            end else begin
                cnt_d = cnt_q[b];
            end
        end

        always_ff @(posedge I_MCLK or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q[b] <= CNT_RST;
            end else begin
                cnt_q[b] <= cnt_d;
            end
        end

        pldb_ram #(
            .AW (ADDR_W),
            .DW (NIB_W)
        ) u_ram (
            .i_clk   (I_MCLK),
            .i_we    (is_wr[b] & store),
            .i_addr  (cnt_q[b]),
            .i_wdata (fifo_out),
            .o_rdata (bank_rd[b])
        );
    end

    // ====================================================================
    // line full flag, print output and readback registers
    logic [NIB_W-1:0]  prn_q, prn_d;
    logic [ADDR_W-1:0] wcnt_q, wcnt_d;
    logic              bank_q;
    logic              sstb_q, radv_q;

    // full at the last address; cleared by a count clear or a swap
    always_comb begin
        wr_full_d = wr_full_q;
        if (I_WRITE_COUNT_CLEAR || bank_q != I_BANK_WRITE_SELECT) begin
            wr_full_d = 1'b0;
        end
        if (store && cnt_q[is_wr[1]] == CNT_MAX) begin
            wr_full_d = 1'b1;
        end
        prn_d = bank_rd[is_wr[0]];
        if (I_TOP_MARGIN_GATE || I_BOTTOM_MARGIN_GATE) begin
            prn_d = NIB_BLANK;
        end
        wcnt_d = cnt_q[is_wr[1]];
    end

    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            wr_full_q <= 1'b0;
            prn_q     <= NIB_BLANK;
            wcnt_q    <= CNT_RST;
            bank_q    <= 1'b0;
            sstb_q    <= 1'b0;
            radv_q    <= 1'b0;
        end else begin
            wr_full_q <= wr_full_d;
            prn_q     <= prn_d;
            wcnt_q    <= wcnt_d;
            bank_q    <= I_BANK_WRITE_SELECT;
            sstb_q    <= store;
            radv_q    <= adv_q;
        end
    end

    assign O_PRINT_NIBBLE         = prn_q;
    assign O_PRINT_READBACK       = prn_q;
    assign O_WRITE_COUNT          = wcnt_q;
    assign O_WRITE_FULL           = wr_full_q;
    assign O_STORED_BYTE_STROBE_N = ~sstb_q;
    assign O_READOUT_ADVANCE_N    = ~radv_q;

endmodule : pldb_top

// ### verif/pldb_far_model.sv
// pldb_far_model: host terminal byte sender and print board dot source.
// assumes one caller at a time, tasks entered on a clock edge.
module pldb_far_model (
    // clock and link status
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic       fault_n,
    // host lines and dot clock
    output logic      [7:0] host_data,
    output logic            strobe_n,
    output logic            dot
);
    timeunit 1ns;
    timeprecision 100ps;
    // dot clock stands low between rows
    initial begin
        host_data = 8'h00;
        strobe_n  = 1'b1;
        dot       = 1'b0;
    end
    // ==========
    // one byte; then waits up to 40 clocks for the ready code, ok reports if it showed
    task automatic send(input logic [7:0] b, output bit ok);
        int n;
        @(posedge clk);
        #1 host_data = b;
        strobe_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 strobe_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 host_data = ~b; // past hold
        for (n = 0; n < 40 && {busy, fault_n} !== 2'h1; n++) begin
            @(posedge clk);
            #1;
        end
        ok = ({busy, fault_n} === 2'h1);
    endtask : send
    // dot pulses, four clocks high and four low
    task automatic dots(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 dot = 1'b1;
            repeat (4) @(posedge clk);
            #1 dot = 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : dots
endmodule : pldb_far_model

// ### verif/pldb_props.sv
// pldb_props: port checks for the print line double buffer.
// assumes a bind into pldb_top, one clock, reset pin active low.
module pldb_props
    import pldb_pkg::*;
#(
    parameter int FIFO_D = FIFO_DEPTH
) (
    // clock and reset
    input wire logic              I_MCLK,
    input wire logic              I_ARST_N,
    // controller lines
    input wire logic              I_ERROR_COND,
    input wire logic              I_BANK_WRITE_SELECT,
    input wire logic              I_WRITE_COUNT_CLEAR,
    input wire logic              I_TOP_MARGIN_GATE,
    input wire logic              I_BOTTOM_MARGIN_GATE,
    // block outputs
    input wire logic              O_BUSY,
    input wire logic              O_FAULT_N,
    input wire logic [NIB_W-1:0]  O_PRINT_NIBBLE,
    input wire logic [NIB_W-1:0]  O_PRINT_READBACK,
    input wire logic              O_STORED_BYTE_STROBE_N,
    input wire logic              O_READOUT_ADVANCE_N,
    input wire logic [ADDR_W-1:0] O_WRITE_COUNT,
    input wire logic              O_WRITE_FULL
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // checks, all off while the reset pin is low
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_ARST_N);
    chk_readback_copy: assert property (
        O_PRINT_READBACK == O_PRINT_NIBBLE) else $error("readback differs");
    chk_margin_blank: assert property (
        I_TOP_MARGIN_GATE || I_BOTTOM_MARGIN_GATE |=> O_PRINT_NIBBLE == NIB_BLANK)
        else $error("print not blanked");
    // the code is registered once
    chk_error_code: assert property (
        I_ERROR_COND [*6] |-> {O_BUSY, O_FAULT_N} == LINK_ERROR) else $error("no error code");
    chk_store_pulse: assert property (
        !O_STORED_BYTE_STROBE_N && !$past(I_WRITE_COUNT_CLEAR)
        && $stable(I_BANK_WRITE_SELECT) |=> $changed(O_WRITE_COUNT)) else $error("no step");
    chk_advance_pulse: assert property (
        !O_READOUT_ADVANCE_N |=> O_READOUT_ADVANCE_N) else $error("advance long");
    chk_count_clear: assert property (
        I_WRITE_COUNT_CLEAR [*3] |-> O_WRITE_COUNT == CNT_RST) else $error("count not clear");
    // clears and bank swaps excluded: both move the count legally
    chk_count_step: assert property (
        $changed(O_WRITE_COUNT) && !$past(I_WRITE_COUNT_CLEAR, 2) && $stable(I_BANK_WRITE_SELECT)
        && $past(I_BANK_WRITE_SELECT, 2) == I_BANK_WRITE_SELECT
        |-> O_WRITE_COUNT == $past(O_WRITE_COUNT) + 11'h001) else $error("bad count step");
    chk_full_stall: assert property (
        O_WRITE_FULL && $past(O_WRITE_FULL) |-> O_STORED_BYTE_STROBE_N)
        else $error("store into full bank");
endmodule : pldb_props

bind pldb_top pldb_props #(.FIFO_D(FIFO_D)) u_props (.*);

// ### verif/testbench.sv
// testbench: row fill, readout per factor, margins, status codes, stall.
// assumes pldb_far_model as host and print board, default fifo depth.
module testbench
    import pldb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // bench signals and model state
    logic clk, rst_n, err, two, inv, bank, wclr, rclr, top, bot, hi, lo;
    logic busy, fault_n, adv_n, full, dot, strobe_n;
    logic [7:0]        host_data;
    logic [NIB_W-1:0]  print;
    logic [ADDR_W-1:0] wcount;
    logic [3:0]        qa[$], qb[$];
    int                seed, bad_count, check_count, adv_count, cycles, k, n;
    bit                ok;
    pldb_top uut (
        .I_MCLK(clk), .I_ARST_N(rst_n), .I_HOST_DATA(host_data),
        .I_HOST_BYTE_STROBE_N(strobe_n), .O_BUSY(busy), .O_FAULT_N(fault_n),
        .O_COMMAND_BYTE(), .I_ERROR_COND(err), .I_TWO_BYTE_PIXEL_SEL(two),
        .I_INVERT_GROUP_SELECT(inv), .I_BANK_WRITE_SELECT(bank),
        .I_WRITE_COUNT_CLEAR(wclr), .I_READ_COUNT_CLEAR(rclr), .I_TOP_MARGIN_GATE(top),
        .I_BOTTOM_MARGIN_GATE(bot), .I_REP_FACTOR_HI(hi), .I_REP_FACTOR_LO(lo),
        .I_MERGED_DOT_CLOCK(dot), .O_PRINT_NIBBLE(print), .O_STORED_BYTE_STROBE_N(),
        .O_READOUT_ADVANCE_N(adv_n), .O_WRITE_COUNT(wcount), .O_PRINT_READBACK(),
        .O_WRITE_FULL(full)
    );
    pldb_far_model far (.clk(clk), .busy(busy), .fault_n(fault_n),
        .host_data(host_data), .strobe_n(strobe_n), .dot(dot));
    // clock, advance count and run ceiling
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (adv_n === 1'b0) adv_count++;
        if (cycles == 40000) begin
            bad_count++;
            summarize();
        end
    end
    // ==========
    // model map: y m c from missing b g r, black and white swap on invert
    function automatic logic [3:0] map_nib(input logic [7:0] b, input logic iv);
        logic [2:0] c;
        c = {~b[1], ~b[3], ~b[5]};
        if (c == 3'h7) return {3'h0, ~iv};
        if (c == 3'h0) return {3'h0, iv};
        return {c, 1'b0};
    endfunction : map_nib
    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string s);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
        end
    endtask : check
    task automatic clears(input logic w, input logic r);
        @(posedge clk);
        #1 wclr = w;
        rclr = r;
        repeat (3) @(posedge clk);
        #1 wclr = 1'b0;
        rclr = 1'b0;
    endtask : clears
    // pixels 0 and 1 are black and white, the rest random
    task automatic fill(input int cnt, input bit tb, ref logic [3:0] q[$]);
        logic [7:0] b;
        for (int i = 0; i < cnt; i++) begin
            b = 8'hc0 | 8'($random(seed)) & 8'h3f;
            if (i < 2) b = (i == 0) ? 8'hc0 : 8'hea;
            far.send(b, ok);
            if (tb) far.send(8'h80 | 8'($random(seed)) & 8'h3f, ok);
            check(12'(ok), 12'h001, "pixel taken");
            q.push_back(map_nib(b, inv));
        end
    endtask : fill
    // divide factor f+1: n advances, each checked against the stored row
    task automatic readout(input int f, input int n, ref logic [3:0] q[$]);
        int a0;
        @(posedge clk);
        #1 {hi, lo} = 2'(f);
        a0 = adv_count;
        repeat (2) @(posedge clk);
        for (int j = 0; j < n; j++) begin
            far.dots(f + 1);
            repeat (6) @(posedge clk);
            #1 k++;
            check(12'(print), 12'(q[k]), "print nibble");
        end
        check(12'(adv_count - a0), 12'(n), "advances");
    endtask : readout
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    // ==========
    // main sequence
    initial begin
        seed = 32'h8900;
        {err, two, inv, bank, wclr, rclr, top, bot, hi, lo} = 10'h000;
        rst_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 check(12'({busy, fault_n}), 12'h001, "ready");
        bank = 1'b1;
        clears(1'b1, 1'b0);
        fill(20, 1'b0, qa);
        repeat (6) @(posedge clk);
        #1 check(12'(wcount), 12'h014, "write count");
        two = 1'b1;
        inv = 1'b1;
        far.send(8'h80, ok);
        check(12'({busy, fault_n}), 12'h000, "resend");
        bank = 1'b0;
        clears(1'b1, 1'b1);
        fill(10, 1'b1, qb);
        repeat (6) @(posedge clk);
        #1 check(12'(wcount), 12'h00a, "two byte count");
        check(12'(print), 12'(qa[0]), "row start");
        k = 0;
        for (int f = 0; f < 4; f++) readout(f, 4, qa);
        bank = 1'b1;
        clears(1'b0, 1'b1);
        repeat (6) @(posedge clk);
        #1 check(12'(print), 12'(qb[0]), "invert row start");
        k = 0;
        readout(0, 8, qb);
        clears(1'b0, 1'b1);
        check(12'(print), 12'(qb[0]), "reprint");
        top = 1'b1;
        repeat (2) @(posedge clk);
        #1 check(12'(print), 12'h000, "top margin");
        {top, bot, err} = 3'h3;
        repeat (8) @(posedge clk);
        #1 check(12'(print), 12'h000, "bottom margin");
        check(12'({busy, fault_n}), 12'h002, "error");
        {bot, err, two} = 3'h0;
        clears(1'b1, 1'b0);
        // fill bank to its last cell, fifo then backs up
        for (n = 0; n < 2100 && (n == 0 || ok); n++) far.send(8'hc0, ok);
        check(12'(full), 12'h001, "bank full");
        check(12'(wcount), 12'h000, "wrapped");
        check(12'(n > 2048 + FIFO_DEPTH), 12'h001, "fifo depth");
        check(12'({busy, fault_n}), 12'h003, "busy stall");
        clears(1'b1, 1'b0);
        repeat (60) @(posedge clk);
        #1 check(12'({busy, fault_n}), 12'h001, "drained");
        summarize();
    end
endmodule : testbench
